/* atc_consts.svh */
/*
 * constants for the conversion trigger comparator: register offsets, field positions, reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

`define ATC_ADDR_W        4
`define ATC_OFF_CTRL      4'h0
`define ATC_OFF_PRIM0     4'h4
`define ATC_OFF_PRIM1     4'h8
`define ATC_OFF_PRIM2     4'hC
`define ATC_OFF_DOWN_BASE 4'h0
`define ATC_CTRL_RESET    16'h0000
`define ATC_CMP_RESET     16'h0000
`define ATC_CE_LSB        0
`define ATC_SEL_LSB       8
`define ATC_CTRL_WMASK    16'h3F3F
`define ATC_SEL_ALL       2'h0
`define ATC_SEL_UP        2'h1
`define ATC_SEL_DOWN      2'h2
`define ATC_SEL_SPLIT     2'h3
`define ATC_CE_OFF        2'h0

`endif

/* atc_pkg.sv */
/*
 * types for the conversion trigger comparator.
 * assumes atc_consts.svh is on the include path.
 */
package atc_pkg;
    typedef enum logic [1:0] {
        ATC_ST_UP   = 2'h0,
        ATC_ST_PEAK = 2'h1,
        ATC_ST_DOWN = 2'h3,
        ATC_ST_ZERO = 2'h2
    } atc_cnt_e;

    typedef struct packed {
        logic [15:0] count;
        atc_cnt_e    state;
    } atc_timer_s;

    typedef struct packed {
        logic [1:0] enableSrc;
        logic [1:0] stateSel;
    } atc_chcfg_s;
endpackage : atc_pkg

/* atc_chan.sv */
/*
 * one comparator channel: picks its timer and qualifies a match by count state.
 * assumes timer inputs already synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "atc_consts.svh"
module atc_chan
    import atc_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire atc_pkg::atc_chcfg_s cfg,
    input  wire atc_pkg::atc_timer_s tmr [3],
    input  wire logic [CW-1:0]       primCmp,
    input  wire logic [CW-1:0]       downCmp,
    output logic                     startReq
);
    atc_timer_s src;
    logic       isUp;
    logic       hit;
    logic       startD;
    logic       startQ;

    always_comb begin
        src = tmr[0];
        case (cfg.enableSrc)
            2'h2:    src = tmr[1];
            2'h3:    src = tmr[2];
            default: src = tmr[0];
        endcase
        isUp = (src.state == ATC_ST_UP);
        case (cfg.stateSel)
            `ATC_SEL_ALL:   hit = (src.count == primCmp);
            `ATC_SEL_UP:    hit = isUp && (src.count == primCmp);
            `ATC_SEL_DOWN:  hit = !isUp && (src.count == primCmp);
            `ATC_SEL_SPLIT: hit = isUp ? (src.count == primCmp) : (src.count == downCmp);
            default:        hit = 1'b0;
        endcase
        // no back-to-back pulses; a held count value pulses every other cycle
        startD = (cfg.enableSrc != `ATC_CE_OFF) && hit && !startQ;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startQ <= 1'b0;
        end else begin
            startQ <= startD;
        end
    end

    assign startReq = startQ;

    off_silent_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(cfg.enableSrc) == `ATC_CE_OFF |-> !startQ) else $error("disabled channel pulsed");
    single_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        startQ |=> !startQ) else $error("start pulse longer than a cycle");
    up_only_a: assert property (@(posedge clk) disable iff (!nrst)
        startQ && $past(cfg.stateSel) == `ATC_SEL_UP |-> $past(isUp)) else $error("up-only fired off up");
    down_only_a: assert property (@(posedge clk) disable iff (!nrst)
        startQ && $past(cfg.stateSel) == `ATC_SEL_DOWN |-> !$past(isUp)) else $error("down-only fired on up");
    all_states_a: assert property (@(posedge clk) disable iff (!nrst)
        startQ && $past(cfg.stateSel) == `ATC_SEL_ALL |-> $past(src.count) == $past(primCmp))
        else $error("all-state fire without primary match");
    split_down_a: assert property (@(posedge clk) disable iff (!nrst)
        startQ && $past(cfg.stateSel) == `ATC_SEL_SPLIT && !$past(isUp) |-> $past(src.count) == $past(downCmp))
        else $error("split fire without down match");
endmodule : atc_chan
`default_nettype wire

/* atc_trigger_compare.sv */
/*
 * conversion trigger comparator: three channels, control and compare registers on wishbone.
 * assumes timer counts/states and bus on clk; master follows classic single cycles.
 */
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "atc_consts.svh"
module atc_trigger_compare
    import atc_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire atc_pkg::atc_timer_s tmr [3],
    output logic [2:0]               convStart
);
    logic [15:0]   ctrl_q,   ctrl_d;
    logic [CW-1:0] prim_q [3];
    logic [CW-1:0] prim_d [3];
    logic [CW-1:0] down_q [3];
    logic [CW-1:0] down_d [3];
    logic [31:0]   rdat_q,   rdat_d;
    logic          ack_q,    ack_d;
    logic          req;
    logic [1:0]    chIdx;
    logic          isDown;
    logic          isCtrl;

    // bit 4 picks the down-compare bank; word offsets within bank
    function automatic logic [1:0] word_of(input logic [7:0] a);
        return a[3:2];
    endfunction : word_of

    always_comb begin
        req    = wb_cyc_i && wb_stb_i && !ack_q;
        isDown = wb_adr_i[4];
        chIdx  = word_of(wb_adr_i) - 2'h1;
        isCtrl = !wb_adr_i[4] && (wb_adr_i[3:0] == `ATC_OFF_CTRL) && (wb_adr_i[7:5] == 3'h0);
        ctrl_d = ctrl_q;
        prim_d = prim_q;
        down_d = down_q;
        rdat_d = 32'h0000_0000;
        ack_d  = req;
        if (req && wb_adr_i[7:5] == 3'h0) begin
            if (isCtrl) begin
                if (wb_we_i) begin
                    if (wb_sel_i[0]) ctrl_d[7:0]  = wb_dat_i[7:0]   & 8'(`ATC_CTRL_WMASK);
                    if (wb_sel_i[1]) ctrl_d[15:8] = wb_dat_i[15:8]  & 8'(`ATC_CTRL_WMASK >> 8);
                end
                rdat_d = {16'h0000, ctrl_q & `ATC_CTRL_WMASK};
            end else if (word_of(wb_adr_i) != 2'h0) begin
                if (wb_we_i && wb_sel_i[1:0] == 2'h3) begin
                    if (isDown) down_d[chIdx] = wb_dat_i[CW-1:0];
                    else        prim_d[chIdx] = wb_dat_i[CW-1:0];
                end
                rdat_d = {16'h0000, isDown ? down_q[chIdx] : prim_q[chIdx]};
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `ATC_CTRL_RESET;
            prim_q <= '{default: `ATC_CMP_RESET};
            down_q <= '{default: `ATC_CMP_RESET};
            rdat_q <= 32'h0000_0000;
            ack_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            prim_q <= prim_d;
            down_q <= down_d;
            rdat_q <= rdat_d;
            ack_q  <= ack_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    // selectors are used live; software keeps them stable while enabled
    for (genvar i = 0; i < 3; i++) begin : g_ch
        atc_chcfg_s cfg;
        assign cfg.enableSrc = ctrl_q[`ATC_CE_LSB + 2*i +: 2];
        assign cfg.stateSel  = ctrl_q[`ATC_SEL_LSB + 2*i +: 2];
        atc_chan #(.CW(CW)) u_chan (
            .clk      (clk),
            .nrst     (nrst),
            .cfg      (cfg),
            .tmr      (tmr),
            .primCmp  (prim_q[i]),
            .downCmp  (down_q[i]),
            .startReq (convStart[i])
        );
    end

    reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_q[15:14] == 2'h0 && ctrl_q[7:6] == 2'h0) else $error("reserved control bits set");
    ack_once_a: assert property (@(posedge clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    sel_write_a: assert property (@(posedge clk) disable iff (!nrst)
        req && isCtrl && wb_we_i && wb_sel_i[1] |=> ctrl_q[13:8] == $past(wb_dat_i[13:8]))
        else $error("selector write lost");
endmodule : atc_trigger_compare
`default_nettype wire

/* atc_timer_model.sv */
/* timer stand-in: three up/down timers whose count and state the bench loads.
   assumes loads arrive synchronous to clk. */
`timescale 1ns/1ns
`default_nettype none
module atc_timer_model (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ld,
    input  wire logic [1:0]          ldIdx,
    input  wire atc_pkg::atc_timer_s ldVal,
    output var  atc_pkg::atc_timer_s tmr [3]
);
    import atc_pkg::*;
    // count jumps instead of stepping, so a match stays one cycle wide
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmr <= '{default: '{16'h0000, ATC_ST_UP}};
        end else if (ld) begin
            tmr[ldIdx] <= ldVal;
        end
    end
endmodule : atc_timer_model
`default_nettype wire

/* adc_start_compare_select_test.sv */
/* self-checking bench: wishbone writes/reads, timer matches per selector and state.
   assumes atc_pkg compiled first and the timer model beside it. */
`timescale 1ns/1ns
`default_nettype none
module adc_start_compare_select_test;
    import atc_pkg::*;
    logic        clk, nrst, cyc, stb, we, ld, ack, m, up, hp;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat;
    logic [2:0]  conv;
    logic [1:0]  ldIdx, t;
    logic [15:0] prim, down, ctl, v;
    atc_timer_s  ldVal;
    atc_timer_s  tmr [3];
    atc_cnt_e    st;
    atc_cnt_e    stTab [4] = '{ATC_ST_UP, ATC_ST_PEAK, ATC_ST_DOWN, ATC_ST_ZERO};
    logic [31:0] rdQ [$];
    logic [2:0]  cvQ [$];
    int          num_errors, checks, cycN;
    atc_trigger_compare atc_trigger_compare_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tmr(tmr), .convStart(conv));
    atc_timer_model atc_timer_model_inst (.clk(clk), .nrst(nrst), .ld(ld), .ldIdx(ldIdx), .ldVal(ldVal),
        .tmr(tmr));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, 16'h0000, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        {cyc, stb} <= 2'b00;
    endtask : wb
    task hit(input logic [1:0] tt, input logic [15:0] vv, input atc_cnt_e s, input logic [2:0] e);
        if (e != 3'b000) cvQ.push_back(e);
        @(posedge clk);
        {ld, ldIdx, ldVal} <= {1'b1, tt, vv, s};
        @(posedge clk);
        ldVal <= '{16'h0000, s};
        @(posedge clk);
        ld <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : hit
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) chk(rdat, rdQ.size() ? rdQ.pop_front() : 32'hFFFFFFFF);
        if (nrst && conv !== 3'b000) chk(32'(conv), cvQ.size() ? 32'(cvQ.pop_front()) : 32'h0);
        cycN++;
        if (cycN == 20000) begin
            num_errors++;
            $display("[ERR] %0t run did not finish", $time);
            end_sim();
        end
    end
    initial begin
        {nrst, cyc, stb, we, ld, adr, dat, ldIdx} = '0;
        sel = 4'hF;
        ldVal = '{16'h0000, ATC_ST_UP};
        {num_errors, checks, cycN} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        void'($urandom(10576));
        rdQ.push_back(32'h00000000);
        wb(1'b0, 8'h00, 16'h0000);
        wb(1'b1, 8'h00, 16'h3F00); // reserved bits written as zero
        rdQ.push_back(32'h00003F00);
        wb(1'b0, 8'h00, 16'h0000);
        rdQ.push_back(32'h00000000);
        wb(1'b0, 8'h10, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 3; c++) begin
                t = 2'((c + s) % 3);
                prim = 16'($urandom) | 16'h0002;
                down = prim ^ 16'h8000;
                wb(1'b1, 8'(4 + 4 * c), prim);
                wb(1'b1, 8'(20 + 4 * c), down);
                ctl = 16'(s << (8 + 2 * c)); // select 00 pass drives peak, down and zero states too
                wb(1'b1, 8'h00, ctl); // selector only moves while disabled
                hit(t, prim, ATC_ST_UP, 3'b000);
                ctl = ctl | 16'((t + 1) << (2 * c));
                wb(1'b1, 8'h00, ctl);
                rdQ.push_back(32'(ctl));
                wb(1'b0, 8'h00, 16'h0000);
                for (int k = 0; k < 8; k++) begin
                    st = stTab[k / 2];
                    v = k[0] ? down : prim;
                    up = (st == ATC_ST_UP);
                    hp = !k[0];
                    m = s == 0 ? hp : s == 1 ? hp & up : s == 2 ? hp & !up : (hp & up) | (!hp & !up);
                    hit(t, v, st, m ? 3'(1 << c) : 3'b000);
                end
                wb(1'b1, 8'h00, 16'h0000);
            end
        end
        repeat (4) @(posedge clk);
        chk(32'(cvQ.size() + rdQ.size()), 32'h00000000);
        end_sim();
    end
endmodule : adc_start_compare_select_test
`default_nettype wire
